/* File: shared/cmbs_pkg.sv */
package cmbs_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Region select in address bits 7:6
    localparam logic [1:0] REG_TX = 2'h0;
    localparam logic [1:0] REG_RX = 2'h1;
    localparam logic [1:0] REG_CTL = 2'h2;
    // Byte slots inside one buffer, word index in address bits 5:2
    localparam logic [3:0] IDX_ID0 = 4'h0;
    localparam logic [3:0] IDX_ID1 = 4'h1;
    localparam logic [3:0] IDX_ID2 = 4'h2;
    localparam logic [3:0] IDX_ID3 = 4'h3;
    localparam logic [3:0] IDX_DATA0 = 4'h4;
    localparam logic [3:0] IDX_DLC = 4'hC;
    localparam logic [3:0] IDX_PRIORITY_VALUE = 4'hD;
    localparam logic [3:0] IDX_STH = 4'hE;
    localparam logic [3:0] IDX_STL = 4'hF;
    // Control region word indexes
    localparam logic [3:0] IDX_SEL = 4'h0;
    localparam logic [3:0] IDX_FLAGS = 4'h1;
    localparam logic [3:0] IDX_CTRL = 4'h2;
    // Field positions
    localparam int ID1_RTR_BIT = 4;
    localparam int ID1_IDE_BIT = 3;
    localparam int ID1_LOW_LSB = 5;
    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_STAMP_BIT = 1;
    // Payload limits
    localparam int MAX_BYTES = 8;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam int STAMP_W = 16;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] SEL_RST = 8'h00;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/cmbs_priority_value_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module cmbs_priority_value_arbiter #(
    parameter int NTX = 3
) (
    input wire logic [NTX-1:0] pending,
    input wire logic [NTX*8-1:0] prioFlat,
    output logic anyPending,
    output logic [$clog2(NTX)-1:0] winIdx
);
    import cmbs_pkg::*;

    // Strict less-than while scanning upward keeps the lower index on ties
    always_comb begin
        logic [7:0] best;
        best = 8'hFF;
        anyPending = 1'b0;
        winIdx = '0;
        for (int i = 0; i < NTX; i++) begin
            if (pending[i] && (!anyPending || prioFlat[i*8 +: 8] < best)) begin
                anyPending = 1'b1;
                best = prioFlat[i*8 +: 8];
                winIdx = i[$clog2(NTX)-1:0];
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/cmbs_stamp_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module cmbs_stamp_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic initMode,
    input wire logic bitTick,
    output logic [cmbs_pkg::STAMP_W-1:0] count
);
    import cmbs_pkg::*;

    logic [STAMP_W-1:0] count_ff;

    // Counts bit clock ticks, held at zero in init mode; wrap is silent
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= '0;
        end else if (ce) begin
            if (initMode) begin
                count_ff <= '0;
            end else if (bitTick) begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    assign count = count_ff;
endmodule
`default_nettype wire

/* File: logic/cmbs_msg_store.sv */
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cmbs_msg_store #(
    parameter int NTX = 3
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [cmbs_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [cmbs_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [cmbs_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [cmbs_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Protocol engine side
    input wire logic bitTick,
    input wire logic sofReq,
    input wire logic txDone,
    input wire logic rxDone,
    input wire logic [10:0] rxId,
    input wire logic rxRtr,
    input wire logic rxIde,
    input wire logic [3:0] rxDlc,
    input wire logic [63:0] rxData,
    output logic txValid,
    output logic [$clog2(NTX)-1:0] txIndex,
    output logic [10:0] txId,
    output logic txRtr,
    output logic txIde,
    output logic [3:0] txDlc,
    output logic [3:0] txByteCount,
    output logic [63:0] txData
);
    import cmbs_pkg::*;

    localparam int IW = $clog2(NTX);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and control state

    // RAM-like buffers: contents undefined after reset, as on real parts
    logic [7:0] txMem [NTX][16];
    logic [7:0] rxMem [16];
    logic [NTX-1:0] txEmpty_ff;
    logic [NTX-1:0] select_ff;
    logic [7:0] ctrl_ff;
    logic [IW-1:0] activeIdx_ff;
    logic txValid_ff;
    logic [IW-1:0] txIndex_ff;
    logic [10:0] txId_ff;
    logic txRtr_ff;
    logic txIde_ff;
    logic [3:0] txDlc_ff;
    logic [3:0] txByteCount_ff;
    logic [63:0] txData_ff;
    logic awready_ff;
    logic wready_ff;
    logic awHeld_ff;
    logic wHeld_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [7:0] wByte_ff;
    logic wLane0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic initMode;
    logic stampEn;
    logic [STAMP_W-1:0] timerVal;
    logic [NTX*8-1:0] prioFlat;
    logic anyPending;
    logic [IW-1:0] winIdx;
    logic [IW-1:0] selIdx;
    logic selOk;
    logic doWrite;
    logic [1:0] wrRegion;
    logic [3:0] wrIdx;
    logic wrMapped;
    logic txWrOk;
    logic [7:0] rdByte;
    logic rdMapped;
    logic [3:0] selDlc;
    logic selRtr;
    logic [3:0] sendCount;
    logic [63:0] sendData;

    assign initMode = ctrl_ff[CTRL_INIT_BIT];
    assign stampEn = ctrl_ff[CTRL_STAMP_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    cmbs_stamp_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .initMode(initMode),
        .bitTick(bitTick),
        .count(timerVal)
    );

    // Priority bytes gathered for the arbiter
    for (genvar g = 0; g < NTX; g++) begin : g_priority_value
        assign prioFlat[g*8 +: 8] = txMem[g][IDX_PRIORITY_VALUE];
    end

    // Only buffers whose empty flag is clear compete
    cmbs_priority_value_arbiter #(.NTX(NTX)) u_arb (
        .pending(~txEmpty_ff),
        .prioFlat(prioFlat),
        .anyPending(anyPending),
        .winIdx(winIdx)
    );

    // Selected buffer index and the access window for software
    always_comb begin
        selIdx = '0;
        for (int i = NTX - 1; i >= 0; i--) begin
            if (select_ff[i]) begin
                selIdx = i[IW-1:0];
            end
        end
    end
    assign selOk = |(select_ff & txEmpty_ff);

    ////////////////////////////////////////////////////////////////////////////////
    // Frame assembly for the winning buffer

    assign selDlc = txMem[winIdx][IDX_DLC][3:0];
    assign selRtr = txMem[winIdx][IDX_ID1][ID1_RTR_BIT];

    // Remote frames send no payload; codes above 8 still mean 8 bytes
    always_comb begin
        if (selRtr) begin
            sendCount = 4'h0;
        end else if (selDlc > DLC_MAX) begin
            sendCount = DLC_MAX;
        end else begin
            sendCount = selDlc;
        end
    end

    // Bytes past the count are masked off the engine port, storage untouched
    for (genvar b = 0; b < MAX_BYTES; b++) begin : g_mask
        assign sendData[b*8 +: 8] = (b < sendCount) ?
            txMem[winIdx][IDX_DATA0 + 4'(b)] : 8'h00;
    end

    // Latch the winner at start of frame; engine sends id bit 10 first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txValid_ff <= 1'b0;
            txIndex_ff <= '0;
            activeIdx_ff <= '0;
            txId_ff <= '0;
            txRtr_ff <= 1'b0;
            txIde_ff <= 1'b0;
            txDlc_ff <= '0;
            txByteCount_ff <= '0;
            txData_ff <= '0;
        end else if (ce) begin
            if (sofReq) begin
                txValid_ff <= anyPending;
                txIndex_ff <= winIdx;
                activeIdx_ff <= winIdx;
                txId_ff <= {txMem[winIdx][IDX_ID0],
                    txMem[winIdx][IDX_ID1][7:ID1_LOW_LSB]};
                txRtr_ff <= selRtr;
                txIde_ff <= txMem[winIdx][IDX_ID1][ID1_IDE_BIT];
                txDlc_ff <= selDlc;
                txByteCount_ff <= sendCount;
                txData_ff <= sendData;
            end else if (txDone) begin
                txValid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels

    assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
    assign wrRegion = awAddr_ff[7:6];
    assign wrIdx = awAddr_ff[5:2];
    assign wrMapped = (wrRegion == REG_TX) || (wrRegion == REG_RX) ||
        ((wrRegion == REG_CTL) && (wrIdx <= IDX_CTRL));
    assign txWrOk = doWrite && wLane0_ff && (wrRegion == REG_TX) && selOk;

    // Address and data taken in either order; response after both
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wByte_ff <= '0;
            wLane0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready_ff) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= awaddr;
                awready_ff <= 1'b0;
            end
            if (wvalid && wready_ff) begin
                wHeld_ff <= 1'b1;
                wByte_ff <= wdata[7:0];
                wLane0_ff <= wstrb[0];
                wready_ff <= 1'b0;
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Software loads the selected buffer; stamp slots are not writable
    always_ff @(posedge clk) begin
        if (ce && txWrOk && wrIdx < IDX_STH) begin
            txMem[selIdx][wrIdx] <= wByte_ff;
        end
        if (ce && txDone && txValid_ff && stampEn) begin
            txMem[activeIdx_ff][IDX_STH] <= timerVal[15:8];
            txMem[activeIdx_ff][IDX_STL] <= timerVal[7:0];
        end
    end

    // Receive buffer filled by the engine as received
    always_ff @(posedge clk) begin
        if (ce && rxDone) begin
            rxMem[IDX_ID0] <= rxId[10:3];
            rxMem[IDX_ID1] <= {rxId[2:0], rxRtr, rxIde, 3'h0};
            rxMem[IDX_DLC] <= {4'h0, rxDlc};
            for (int i = 0; i < MAX_BYTES; i++) begin
                rxMem[IDX_DATA0 + i[3:0]] <= rxData[i*8 +: 8];
            end
            if (stampEn) begin
                rxMem[IDX_STH] <= timerVal[15:8];
                rxMem[IDX_STL] <= timerVal[7:0];
            end
        end
    end

    // Selection keeps only the lowest written bit that names an empty buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            select_ff <= SEL_RST[NTX-1:0];
        end else if (ce && doWrite && wLane0_ff && wrRegion == REG_CTL &&
            wrIdx == IDX_SEL) begin
            select_ff <= '0;
            for (int i = NTX - 1; i >= 0; i--) begin
                if (wByte_ff[i] && txEmpty_ff[i]) begin
                    select_ff <= NTX'(1) << i;
                end
            end
        end
    end

    // Empty flags: write one to clear marks ready; sent frame sets it back
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txEmpty_ff <= '1;
        end else if (ce) begin
            for (int i = 0; i < NTX; i++) begin
                if (txDone && txValid_ff && activeIdx_ff == i[IW-1:0]) begin
                    txEmpty_ff[i] <= 1'b1;
                end else if (doWrite && wLane0_ff && wrRegion == REG_CTL &&
                    wrIdx == IDX_FLAGS && wByte_ff[i]) begin
                    txEmpty_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Init mode and stamp enable bits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else if (ce && doWrite && wLane0_ff && wrRegion == REG_CTL &&
            wrIdx == IDX_CTRL) begin
            ctrl_ff <= {6'h00, wByte_ff[CTRL_STAMP_BIT], wByte_ff[CTRL_INIT_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channels

    // Read decode; closed transmit slots read zero
    always_comb begin
        rdByte = 8'h00;
        rdMapped = 1'b1;
        unique case (araddr[7:6])
            REG_TX: begin
                if (selOk) begin
                    rdByte = txMem[selIdx][araddr[5:2]];
                end
            end
            REG_RX: begin
                rdByte = rxMem[araddr[5:2]];
            end
            REG_CTL: begin
                if (araddr[5:2] == IDX_SEL) begin
                    rdByte = 8'(select_ff);
                end else if (araddr[5:2] == IDX_FLAGS) begin
                    rdByte = 8'(txEmpty_ff);
                end else if (araddr[5:2] == IDX_CTRL) begin
                    rdByte = ctrl_ff;
                end else begin
                    rdMapped = 1'b0;
                end
            end
            default: begin
                rdMapped = 1'b0;
            end
        endcase
    end

    // One cycle from address taken to data valid
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h00_0000, rdByte};
                rresp_ff <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign txValid = txValid_ff;
    assign txIndex = txIndex_ff;
    assign txId = txId_ff;
    assign txRtr = txRtr_ff;
    assign txIde = txIde_ff;
    assign txDlc = txDlc_ff;
    assign txByteCount = txByteCount_ff;
    assign txData = txData_ff;
endmodule
`default_nettype wire

/* File: bench/cmbs_msg_store_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cmbs_msg_store_chk #(
    parameter int NTX = 3
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sofReq,
    input wire logic txDone,
    input wire logic txValid,
    input wire logic [$clog2(NTX)-1:0] txIndex,
    input wire logic [10:0] txId,
    input wire logic txRtr,
    input wire logic [3:0] txDlc,
    input wire logic [3:0] txByteCount,
    input wire logic [63:0] txData
);
    // Single domain, so clock and reset are stated once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    property p_frameNeedsSof;
        $rose(txValid) |-> $past(sofReq && ce);
    endproperty
    a_frameNeedsSof: assert property (p_frameNeedsSof)
        else $error("frame latched without a start request");
    property p_idleStaysIdle;
        !txValid && !(sofReq && ce) |=> !txValid;
    endproperty
    a_idleStaysIdle: assert property (p_idleStaysIdle)
        else $error("frame appeared while idle");
    property p_frameHeld;
        txValid && !(sofReq && ce) && !(txDone && ce) |=>
            txValid && $stable(txId) && $stable(txIndex);
    endproperty
    a_frameHeld: assert property (p_frameHeld)
        else $error("latched frame changed between requests");
    property p_doneRetires;
        txValid && txDone && ce && !sofReq |=> !txValid;
    endproperty
    a_doneRetires: assert property (p_doneRetires)
        else $error("frame still held after completion");
    property p_remoteNoBytes;
        txValid && txRtr |-> txByteCount == 4'h0;
    endproperty
    a_remoteNoBytes: assert property (p_remoteNoBytes)
        else $error("remote frame carries payload bytes");
    property p_countFollowsCode;
        txValid && !txRtr && txDlc <= 4'h8 |-> txByteCount == txDlc;
    endproperty
    a_countFollowsCode: assert property (p_countFollowsCode)
        else $error("byte count differs from length code");
    property p_longCodeEight;
        txValid && !txRtr && txDlc > 4'h8 |-> txByteCount == 4'h8;
    endproperty
    a_longCodeEight: assert property (p_longCodeEight)
        else $error("oversized length code not capped at eight");
    property p_extraBytesHidden;
        txValid && txByteCount < 4'h8 |-> (txData >> {txByteCount, 3'b000}) == 64'h0;
    endproperty
    a_extraBytesHidden: assert property (p_extraBytesHidden)
        else $error("bytes past the count reach the engine");
endmodule

bind cmbs_msg_store cmbs_msg_store_chk #(.NTX(NTX)) chk_u (.clk(clk), .rstn(rstn), .ce(ce),
    .sofReq(sofReq), .txDone(txDone), .txValid(txValid), .txIndex(txIndex), .txId(txId),
    .txRtr(txRtr), .txDlc(txDlc), .txByteCount(txByteCount), .txData(txData));
`default_nettype wire

/* File: bench/cmbs_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cmbs_engine_model (
    input wire logic clk,
    output logic bitTick,
    output logic sofReq,
    output logic txDone,
    output logic rxDone,
    output logic [10:0] rxId,
    output logic rxRtr,
    output logic rxIde,
    output logic [3:0] rxDlc,
    output logic [63:0] rxData
);
    // Idle fields show a pattern, never a stale copy of the last frame
    initial begin
        bitTick = 1'b0;
        sofReq = 1'b0;
        txDone = 1'b0;
        rxDone = 1'b0;
        {rxId, rxRtr, rxIde, rxDlc, rxData} = {1'b1, {40{2'b10}}};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bit clock ticks, one every second cycle
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            bitTick <= 1'b1;
            @(posedge clk);
            bitTick <= 1'b0;
        end
    endtask
    // Start request or successful completion; outputs settle by return
    task automatic strobe(input bit isDone);
        @(posedge clk);
        if (isDone) txDone <= 1'b1;
        else sofReq <= 1'b1;
        @(posedge clk);
        txDone <= 1'b0;
        sofReq <= 1'b0;
        #1;
    endtask
    // Valid received frame, fields inverted once the strobe is gone
    task automatic recv(input logic [10:0] id, input logic rtr, input logic ide,
        input logic [3:0] dlc, input logic [63:0] d);
        @(posedge clk);
        {rxId, rxRtr, rxIde, rxDlc, rxData} <= {id, rtr, ide, dlc, d};
        rxDone <= 1'b1;
        @(posedge clk);
        {rxId, rxRtr, rxIde, rxDlc, rxData} <= ~{id, rtr, ide, dlc, d};
        rxDone <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: bench/cmbs_msg_store_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module cmbs_msg_store_bench;
    import cmbs_pkg::*;
    typedef struct packed {logic [3:0] dlc; logic rtr; logic [3:0] cnt;} cmbs_row_s;
    logic clk = 1'b0;
    logic rstn, ce;
    logic [3:0] wstrb;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, txValid, txRtr, txIde;
    logic [1:0] bresp, rresp, txIndex, lastResp;
    logic bitTick, sofReq, txDone, rxDone, rxRtr, rxIde;
    logic [10:0] rxId, txId;
    logic [3:0] rxDlc, txDlc, txByteCount;
    logic [63:0] rxData, txData;
    int n_mismatch = 0;
    int num_checks = 0;
    // Length code rows: code, remote flag, bytes expected on the wire
    cmbs_row_s rows [6] = '{'{4'h0, 1'b0, 4'h0}, '{4'h1, 1'b0, 4'h1}, '{4'h8, 1'b0, 4'h8},
        '{4'hF, 1'b0, 4'h8}, '{4'h5, 1'b1, 4'h0}, '{4'h3, 1'b0, 4'h3}};

    cmbs_msg_store #(.NTX(3)) dut_u (.clk, .rstn, .ce, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .bitTick, .sofReq, .txDone, .rxDone, .rxId,
        .rxRtr, .rxIde, .rxDlc, .rxData, .txValid, .txIndex, .txId, .txRtr, .txIde, .txDlc,
        .txByteCount, .txData);
    cmbs_engine_model eng_u (.clk, .bitTick, .sofReq, .txDone, .rxDone, .rxId, .rxRtr,
        .rxIde, .rxDlc, .rxData);

    always #5 clk = ~clk;
    // Whole run is well under two thousand cycles; this only cuts a hang
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ad(input logic [1:0] r, input logic [3:0] i);
        return {r, i, 2'b00};
    endfunction
    // Address and data offered together, each dropped once taken
    task automatic axW(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {awaddr, wdata} <= {a, 24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        lastResp = bresp;
    endtask
    task automatic axR(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        lastResp = rresp;
        chk(rdata, {24'h0, exp});
    endtask
    // Software order: select, fill, then release by clearing the empty flag
    task automatic load(input int b, input logic [10:0] id, input logic rtr,
        input logic [3:0] dlc, input logic [7:0] pr);
        axW(ad(REG_CTL, IDX_SEL), 8'(1 << b));
        axW(ad(REG_TX, IDX_ID0), id[10:3]);
        axW(ad(REG_TX, IDX_ID1), {id[2:0], rtr, id[0], 3'h0});
        axW(ad(REG_TX, IDX_ID2), 8'hFF);
        for (int i = 0; i < 8; i++) axW(ad(REG_TX, IDX_DATA0 + 4'(i)), 8'h10 + 8'(i));
        axW(ad(REG_TX, IDX_DLC), {4'h0, dlc});
        axW(ad(REG_TX, IDX_PRIORITY_VALUE), pr);
        axW(ad(REG_CTL, IDX_FLAGS), 8'(1 << b));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] expData;
        logic [10:0] id;
        rstn <= 1'b0;
        ce <= 1'b1;
        wstrb <= 4'h1;
        {awaddr, araddr, wdata} <= '0;
        {awvalid, wvalid, bready, arvalid, rready} <= '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        axR(ad(REG_CTL, IDX_SEL), SEL_RST);
        axR(ad(REG_CTL, IDX_FLAGS), 8'h07);
        axR(ad(REG_CTL, IDX_CTRL), CTRL_RST);
        axW(ad(REG_CTL, IDX_CTRL), 8'h00);
        // Ordinary frames, one buffer each time
        foreach (rows[r]) begin
            id = 11'h2A5 + 11'(r);
            load(0, id, rows[r].rtr, rows[r].dlc, 8'h00);
            expData = '0;
            for (int i = 0; i < 8; i++) if (i < rows[r].cnt) expData[8*i +: 8] = 8'h10 + 8'(i);
            eng_u.strobe(1'b0);
            chk(txId, id);
            chk(txRtr, rows[r].rtr);
            chk(txIde, id[0]);
            chk(txDlc, rows[r].dlc);
            chk(txByteCount, rows[r].cnt);
            chk(txData, expData);
            eng_u.strobe(1'b1);
            axR(ad(REG_CTL, IDX_FLAGS), 8'h07);
        end
        // Three pending, lowest value shared by buffers 1 and 2
        load(0, 11'h100, 1'b0, 4'h1, 8'h05);
        load(1, 11'h200, 1'b0, 4'h1, 8'h03);
        load(2, 11'h300, 1'b0, 4'h1, 8'h03);
        axR(ad(REG_TX, IDX_PRIORITY_VALUE), 8'h00);
        eng_u.strobe(1'b0);
        chk(txIndex, 2'd1);
        chk(txId, 11'h200);
        eng_u.strobe(1'b1);
        eng_u.strobe(1'b0);
        chk(txIndex, 2'd2);
        eng_u.strobe(1'b1);
        eng_u.strobe(1'b0);
        chk(txIndex, 2'd0);
        eng_u.strobe(1'b1);
        // Timer held at zero in init mode, then a known tick count
        axW(ad(REG_CTL, IDX_CTRL), 8'h03);
        eng_u.tick(3);
        eng_u.recv(11'h5A3, 1'b1, 1'b0, 4'h8, 64'h0123);
        axR(ad(REG_RX, IDX_STL), 8'h00);
        axW(ad(REG_CTL, IDX_CTRL), 8'h02);
        eng_u.tick(259);
        eng_u.recv(11'h5A3, 1'b1, 1'b1, 4'h2, 64'hBEEF);
        axR(ad(REG_RX, IDX_ID0), 8'hB4);
        axR(ad(REG_RX, IDX_ID1), 8'h78);
        axR(ad(REG_RX, IDX_DLC), 8'h02);
        axR(ad(REG_RX, IDX_DATA0), 8'hEF);
        axR(ad(REG_RX, IDX_STH), 8'h01);
        axR(ad(REG_RX, IDX_STL), 8'h03);
        axW(ad(REG_RX, IDX_STL), 8'h55);
        axR(ad(REG_RX, IDX_STL), 8'h03);
        // Lane zero off: write ignored, init mode stays off
        wstrb <= 4'h0;
        axW(ad(REG_CTL, IDX_CTRL), 8'h01);
        wstrb <= 4'hF;
        axR(ad(REG_CTL, IDX_CTRL), 8'h02);
        // Frozen enable drops a start request; the retry latches and is stamped
        load(0, 11'h123, 1'b0, 4'h2, 8'h00);
        ce <= 1'b0;
        eng_u.strobe(1'b0);
        chk(txValid, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        eng_u.strobe(1'b0);
        chk(txValid, 1'b1);
        chk(txId, 11'h123);
        eng_u.strobe(1'b1);
        axR(ad(REG_TX, IDX_STL), 8'h03);
        // Hole in the map, then a second reset in mid-run
        axW(ad(REG_CTL, 4'h4), 8'h00);
        chk(lastResp, RESP_SLVERR);
        axR(ad(REG_CTL, 4'h4), 8'h00);
        chk(lastResp, RESP_SLVERR);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        axR(ad(REG_CTL, IDX_CTRL), CTRL_RST);
        stop_test();
    end
endmodule
`default_nettype wire
